// ==== core_sfr_bank_consts.vh ====
// Register offsets, reset values and field positions of the core register bank.
`ifndef CORE_SFR_BANK_CONSTS_VH
`define CORE_SFR_BANK_CONSTS_VH

// ****************************************************************
// Register offsets in the data memory map
// ****************************************************************
`define A_STACK_TOP_UPPER 12'hfff
`define A_STACK_TOP_HIGH 12'hffe
`define A_STACK_TOP_LOW 12'hffd
`define A_STACK_POINTER 12'hffc
`define A_PC_UPPER_LATCH 12'hffb
`define A_PC_HIGH_LATCH 12'hffa
`define A_PC_LOW_BYTE 12'hff9
`define A_TBL_PTR_UPPER 12'hff8
`define A_TBL_PTR_HIGH 12'hff7
`define A_TBL_PTR_LOW 12'hff6
`define A_TBL_LATCH 12'hff5
`define A_PROD_HIGH 12'hff4
`define A_PROD_LOW 12'hff3
`define A_INT_CTRL_MAIN 12'hff2
`define A_INT_CTRL_EDGES 12'hff1
`define A_INT_CTRL_EXT 12'hff0
`define A_IND0_PLAIN 12'hfef
`define A_IND0_POST_INC 12'hfee
`define A_IND0_POST_DEC 12'hfed
`define A_IND0_PRE_INC 12'hfec
`define A_IND0_PLUS_W 12'hfeb
`define A_IND0_PTR_HIGH 12'hfea
`define A_IND0_PTR_LOW 12'hfe9
`define A_WORKING 12'hfe8
`define A_EVENT_STATUS 12'hf60
`define A_EVENT_MASK 12'hf61

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_ZERO 8'h00
`define RST_INT_CTRL_EDGES 8'hff
`define RST_INT_CTRL_EXT 8'hc0

// ****************************************************************
// Field positions
// ****************************************************************
`define STK_FULL_BIT 7
`define STK_UNDERFLOW_BIT 6
`define STK_PTR_MAX 5'h1f
`define EV_FULL_BIT 0
`define EV_UNDERFLOW_BIT 1
`define TBL_CONFIG_BIT 5
`define PC_BIT21 5

`endif

// ==== core_sfr_bank.v ====
// Core special function register bank with indirect pointer zero access.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/100ps
`include "core_sfr_bank_consts.vh"

module core_sfr_bank #(
  parameter MEM_DEPTH = 256,
  parameter MEM_AW = 8
)(
  input wire clock_i,
  input wire rst_i,
  input wire [11:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire push_i,
  input wire pop_i,
  input wire [20:0] ret_addr_i,
  input wire tbl_load_i,
  input wire [7:0] tbl_data_i,
  input wire mul_load_i,
  input wire [15:0] product_i,
  output reg pc_load_o,
  output reg [20:0] pc_target_o,
  output reg [21:0] table_ptr_o,
  output reg table_config_sel_o,
  output reg [7:0] table_latch_o,
  output reg [7:0] int_ctrl_main_o,
  output reg irq_o
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  reg [7:0] stack_top_upper;
  reg [7:0] stack_top_high;
  reg [7:0] stack_top_low;
  reg [4:0] stack_ptr;
  reg stack_full_flag;
  reg stack_underflow_flag;
  reg [5:0] pc_upper_latch;
  reg [7:0] pc_high_latch;
  reg [7:0] pc_low_byte;
  reg [5:0] table_pointer_upper;
  reg [7:0] table_pointer_high;
  reg [7:0] table_pointer_low;
  reg [7:0] table_data_latch;
  reg [7:0] multiply_result_high;
  reg [7:0] multiply_result_low;
  reg [7:0] interrupt_control_main;
  reg [7:0] interrupt_control_edges;
  reg [7:0] interrupt_control_external;
  reg [11:0] indirect_pointer_zero;
  reg [7:0] working_register;
  reg [1:0] event_status;
  reg [1:0] event_mask;
  reg [7:0] mem [0:MEM_DEPTH-1];

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire acc;
  wire is_plain;
  wire is_post_inc;
  wire is_post_dec;
  wire is_pre_inc;
  wire is_plus_w;
  wire is_indirect;
  wire is_direct_mem;
  reg [11:0] eff_ptr;
  reg [11:0] next_ptr;
  reg [11:0] tgt_addr;
  reg tgt_mem;
  reg [7:0] next_rdata;
  reg [1:0] next_status;
  wire [1:0] ev_set;
  wire [1:0] ev_clr;

  assign acc = wr_i | rd_i;
  assign is_plain = (addr_i == `A_IND0_PLAIN);
  assign is_post_inc = (addr_i == `A_IND0_POST_INC);
  assign is_post_dec = (addr_i == `A_IND0_POST_DEC);
  assign is_pre_inc = (addr_i == `A_IND0_PRE_INC);
  assign is_plus_w = (addr_i == `A_IND0_PLUS_W);
  assign is_indirect = is_plain | is_post_inc | is_post_dec | is_pre_inc | is_plus_w;
  // Plain data memory sits below the implemented depth
  assign is_direct_mem = (addr_i < MEM_DEPTH);

  // Effective address and pointer update of the indirect locations
  always @*
  begin
    eff_ptr = indirect_pointer_zero;
    next_ptr = indirect_pointer_zero;
    if (is_pre_inc)
    begin
      eff_ptr = indirect_pointer_zero + 12'h001;
      next_ptr = eff_ptr;
    end
    else if (is_post_inc)
      next_ptr = indirect_pointer_zero + 12'h001;
    else if (is_post_dec)
      next_ptr = indirect_pointer_zero - 12'h001;
    else if (is_plus_w)
    begin
      // Signed offset, pointer itself unchanged
      eff_ptr = indirect_pointer_zero + {{4{working_register[7]}}, working_register};
    end
  end

  // Target byte: indirect locations resolve to a memory address
  always @*
  begin
    tgt_addr = addr_i;
    if (is_indirect)
      tgt_addr = eff_ptr;
    // Indirect reach into the register area is not supported; reads zero
    tgt_mem = (tgt_addr < MEM_DEPTH);
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  always @*
  begin
    next_rdata = 8'h00;
    if (tgt_mem && (is_indirect || is_direct_mem))
      next_rdata = mem[tgt_addr[MEM_AW-1:0]];
    else
      case (addr_i)
        `A_STACK_TOP_UPPER: next_rdata = {3'b000, stack_top_upper[4:0]};
        `A_STACK_TOP_HIGH: next_rdata = stack_top_high;
        `A_STACK_TOP_LOW: next_rdata = stack_top_low;
        `A_STACK_POINTER: next_rdata = {stack_full_flag, stack_underflow_flag, 1'b0, stack_ptr};
        `A_PC_UPPER_LATCH: next_rdata = {2'b00, pc_upper_latch};
        `A_PC_HIGH_LATCH: next_rdata = pc_high_latch;
        `A_PC_LOW_BYTE: next_rdata = pc_low_byte;
        `A_TBL_PTR_UPPER: next_rdata = {2'b00, table_pointer_upper};
        `A_TBL_PTR_HIGH: next_rdata = table_pointer_high;
        `A_TBL_PTR_LOW: next_rdata = table_pointer_low;
        `A_TBL_LATCH: next_rdata = table_data_latch;
        `A_PROD_HIGH: next_rdata = multiply_result_high;
        `A_PROD_LOW: next_rdata = multiply_result_low;
        `A_INT_CTRL_MAIN: next_rdata = interrupt_control_main;
        `A_INT_CTRL_EDGES: next_rdata = interrupt_control_edges;
        `A_INT_CTRL_EXT: next_rdata = interrupt_control_external;
        `A_IND0_PTR_HIGH: next_rdata = {4'h0, indirect_pointer_zero[11:8]};
        `A_IND0_PTR_LOW: next_rdata = indirect_pointer_zero[7:0];
        `A_WORKING: next_rdata = working_register;
        `A_EVENT_STATUS: next_rdata = {6'b00_0000, event_status};
        `A_EVENT_MASK: next_rdata = {6'b00_0000, event_mask};
        default: next_rdata = 8'h00;
      endcase
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else
      rdata_o <= rd_i ? next_rdata : 8'h00;
  end

  // ****************************************************************
  // Data memory
  // ****************************************************************
  // No reset: plain storage, contents undefined at power-up
  always @(posedge clock_i)
  begin
    if (wr_i && tgt_mem && (is_indirect || is_direct_mem))
      mem[tgt_addr[MEM_AW-1:0]] <= wdata_i;
  end

  // ****************************************************************
  // Indirect pointer zero and working register
  // ****************************************************************
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      indirect_pointer_zero <= 12'h000;
      working_register <= 8'h00;
    end
    else
    begin
      // Upper nibble of a high byte write is not stored
      if (acc && (is_post_inc || is_post_dec || is_pre_inc))
        indirect_pointer_zero <= next_ptr;
      else if (wr_i && addr_i == `A_IND0_PTR_HIGH)
        indirect_pointer_zero[11:8] <= wdata_i[3:0];
      else if (wr_i && addr_i == `A_IND0_PTR_LOW)
        indirect_pointer_zero[7:0] <= wdata_i;
      if (wr_i && addr_i == `A_WORKING)
        working_register <= wdata_i;
    end
  end

  // ****************************************************************
  // Return stack top and pointer
  // ****************************************************************
  // Overflow and underflow raise flags, the pointer saturates
  assign ev_set[`EV_FULL_BIT] = push_i && (stack_ptr == `STK_PTR_MAX - 5'h01 || stack_full_flag
    || stack_ptr == `STK_PTR_MAX);
  assign ev_set[`EV_UNDERFLOW_BIT] = pop_i && (stack_ptr == 5'h00);

  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stack_top_upper <= `RST_ZERO;
      stack_top_high <= `RST_ZERO;
      stack_top_low <= `RST_ZERO;
      stack_ptr <= 5'h00;
      stack_full_flag <= 1'b0;
      stack_underflow_flag <= 1'b0;
    end
    else
    begin
      if (push_i)
      begin
        if (stack_ptr != `STK_PTR_MAX)
          stack_ptr <= stack_ptr + 5'h01;
        stack_top_upper <= {3'b000, ret_addr_i[20:16]};
        stack_top_high <= ret_addr_i[15:8];
        stack_top_low <= ret_addr_i[7:0];
      end
      else if (pop_i)
      begin
        if (stack_ptr != 5'h00)
          stack_ptr <= stack_ptr - 5'h01;
      end
      else if (wr_i)
      begin
        case (addr_i)
          `A_STACK_TOP_UPPER: stack_top_upper <= {3'b000, wdata_i[4:0]};
          `A_STACK_TOP_HIGH: stack_top_high <= wdata_i;
          `A_STACK_TOP_LOW: stack_top_low <= wdata_i;
          `A_STACK_POINTER: stack_ptr <= wdata_i[4:0];
          default: stack_ptr <= stack_ptr;
        endcase
      end
      // Flags are set by hardware; software clears them by writing zero
      if (ev_set[`EV_FULL_BIT])
        stack_full_flag <= 1'b1;
      else if (wr_i && addr_i == `A_STACK_POINTER && !wdata_i[`STK_FULL_BIT])
        stack_full_flag <= 1'b0;
      if (ev_set[`EV_UNDERFLOW_BIT])
        stack_underflow_flag <= 1'b1;
      else if (wr_i && addr_i == `A_STACK_POINTER && !wdata_i[`STK_UNDERFLOW_BIT])
        stack_underflow_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // Program counter latches
  // ****************************************************************
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pc_upper_latch <= 6'h00;
      pc_high_latch <= `RST_ZERO;
      pc_low_byte <= `RST_ZERO;
      pc_load_o <= 1'b0;
      pc_target_o <= 21'h00_0000;
    end
    else
    begin
      pc_load_o <= 1'b0;
      if (wr_i && addr_i == `A_PC_UPPER_LATCH)
        pc_upper_latch <= wdata_i[5:0];
      if (wr_i && addr_i == `A_PC_HIGH_LATCH)
        pc_high_latch <= wdata_i;
      // A write to the low byte loads the whole counter from the latches and the written byte
      if (wr_i && addr_i == `A_PC_LOW_BYTE)
      begin
        pc_low_byte <= wdata_i;
        pc_load_o <= 1'b1;
        pc_target_o <= {pc_upper_latch[4:0], pc_high_latch, wdata_i};
      end
    end
  end

  // ****************************************************************
  // Table pointer and table latch
  // ****************************************************************
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      table_pointer_upper <= 6'h00;
      table_pointer_high <= `RST_ZERO;
      table_pointer_low <= `RST_ZERO;
      table_data_latch <= `RST_ZERO;
    end
    else
    begin
      if (wr_i && addr_i == `A_TBL_PTR_UPPER)
        table_pointer_upper <= wdata_i[5:0];
      if (wr_i && addr_i == `A_TBL_PTR_HIGH)
        table_pointer_high <= wdata_i;
      if (wr_i && addr_i == `A_TBL_PTR_LOW)
        table_pointer_low <= wdata_i;
      // A table read from program memory wins over a software write
      if (tbl_load_i)
        table_data_latch <= tbl_data_i;
      else if (wr_i && addr_i == `A_TBL_LATCH)
        table_data_latch <= wdata_i;
    end
  end

  // Registered copies keep the outputs straight from flip-flops
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      table_ptr_o <= 22'h00_0000;
      table_config_sel_o <= 1'b0;
      table_latch_o <= 8'h00;
    end
    else
    begin
      table_ptr_o <= {table_pointer_upper, table_pointer_high, table_pointer_low};
      table_config_sel_o <= table_pointer_upper[`TBL_CONFIG_BIT];
      table_latch_o <= table_data_latch;
    end
  end

  // ****************************************************************
  // Multiplier product
  // ****************************************************************
  // Left without reset: its power-up content carries no meaning
  always @(posedge clock_i)
  begin
    if (mul_load_i)
    begin
      multiply_result_high <= product_i[15:8];
      multiply_result_low <= product_i[7:0];
    end
    else if (wr_i && addr_i == `A_PROD_HIGH)
      multiply_result_high <= wdata_i;
    else if (wr_i && addr_i == `A_PROD_LOW)
      multiply_result_low <= wdata_i;
  end

  // ****************************************************************
  // Interrupt control words
  // ****************************************************************
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      interrupt_control_main <= `RST_ZERO;
      interrupt_control_edges <= `RST_INT_CTRL_EDGES;
      interrupt_control_external <= `RST_INT_CTRL_EXT;
      int_ctrl_main_o <= `RST_ZERO;
    end
    else
    begin
      if (wr_i && addr_i == `A_INT_CTRL_MAIN)
        interrupt_control_main <= wdata_i;
      if (wr_i && addr_i == `A_INT_CTRL_EDGES)
        interrupt_control_edges <= wdata_i;
      if (wr_i && addr_i == `A_INT_CTRL_EXT)
        interrupt_control_external <= wdata_i;
      int_ctrl_main_o <= interrupt_control_main;
    end
  end

  // ****************************************************************
  // Stack event status, mask and interrupt line
  // ****************************************************************
  // Write one to clear; a new event in the same cycle wins
  assign ev_clr = (wr_i && addr_i == `A_EVENT_STATUS) ? wdata_i[1:0] : 2'b00;

  always @*
  begin
    next_status = (event_status & ~ev_clr) | ev_set;
  end

  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      event_status <= 2'b00;
      event_mask <= 2'b00;
      irq_o <= 1'b0;
    end
    else
    begin
      event_status <= next_status;
      if (wr_i && addr_i == `A_EVENT_MASK)
        event_mask <= wdata_i[1:0];
      irq_o <= |(next_status & event_mask);
    end
  end

endmodule // core_sfr_bank

// ==== core_sfr_bank_asserts.sv ====
// Port-level checker for the core register bank, bound into every instance.
`timescale 1ns/100ps
`include "core_sfr_bank_consts.vh"

module core_sfr_bank_asserts (
  input wire clock_i,
  input wire rst_i,
  input wire [11:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire tbl_load_i,
  input wire [7:0] tbl_data_i,
  input wire pc_load_o,
  input wire [20:0] pc_target_o,
  input wire [21:0] table_ptr_o,
  input wire table_config_sel_o,
  input wire [7:0] table_latch_o
);
  // ****************************************************************
  // Common clock and reset
  // ****************************************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  // Low byte write must fire the load pulse with the written byte
  AST_PC_LOAD_FOLLOWS: assert property (
    (wr_i && addr_i == `A_PC_LOW_BYTE) |=> pc_load_o)
    else $error("pc load pulse missing after low byte write");
  AST_PC_TARGET_LOW: assert property (
    (wr_i && addr_i == `A_PC_LOW_BYTE) |=> pc_target_o[7:0] == $past(wdata_i))
    else $error("pc target low byte differs from written byte");
  // A stray pulse would jump the core to a stale target
  AST_PC_LOAD_CAUSE: assert property (
    pc_load_o |-> $past(wr_i && addr_i == `A_PC_LOW_BYTE))
    else $error("pc load pulse without low byte write");
  AST_PC_TARGET_HOLD: assert property (
    !pc_load_o |-> $stable(pc_target_o))
    else $error("pc target moved without load");

  // Table pointer bytes reach the output two edges after the write
  AST_TBL_HIGH: assert property (
    (wr_i && addr_i == `A_TBL_PTR_HIGH) |-> ##2 table_ptr_o[15:8] == $past(wdata_i, 2))
    else $error("table pointer high byte not mapped");
  AST_TBL_LOW: assert property (
    (wr_i && addr_i == `A_TBL_PTR_LOW) |-> ##2 table_ptr_o[7:0] == $past(wdata_i, 2))
    else $error("table pointer low byte not mapped");
  AST_TBL_LATCH: assert property (
    tbl_load_i |-> ##2 table_latch_o == $past(tbl_data_i, 2))
    else $error("table latch did not take program memory byte");
  AST_CFG_SEL: assert property (
    (wr_i && addr_i == `A_TBL_PTR_UPPER) |-> ##2
      table_config_sel_o == $past(wdata_i[`TBL_CONFIG_BIT], 2))
    else $error("configuration select differs from written bit 21");
  AST_PTR_HIGH_NIBBLE: assert property (
    (rd_i && addr_i == `A_IND0_PTR_HIGH) |=> rdata_o[7:4] == 4'h0)
    else $error("pointer zero high nibble not zero");
endmodule // core_sfr_bank_asserts

bind core_sfr_bank core_sfr_bank_asserts i_core_sfr_bank_asserts (
  .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tbl_load_i(tbl_load_i),
  .tbl_data_i(tbl_data_i), .pc_load_o(pc_load_o), .pc_target_o(pc_target_o),
  .table_ptr_o(table_ptr_o), .table_config_sel_o(table_config_sel_o),
  .table_latch_o(table_latch_o));

// ==== testbench.sv ====
// Self-checking testbench for the core register bank.
`timescale 1ns/100ps
`include "core_sfr_bank_consts.vh"

module testbench;
  reg clock_i = 1'b0;
  reg rst_i = 1'b1;
  reg [11:0] addr_i = 12'h000;
  reg [7:0] wdata_i = 8'h00;
  reg wr_i = 1'b0, rd_i = 1'b0, push_i = 1'b0, pop_i = 1'b0;
  reg tbl_load_i = 1'b0, mul_load_i = 1'b0;
  reg [20:0] ret_addr_i = 21'h00_0000;
  reg [7:0] tbl_data_i = 8'h00;
  reg [15:0] product_i = 16'h0000;
  wire [7:0] rdata_o, table_latch_o, int_ctrl_main_o;
  wire pc_load_o, table_config_sel_o, irq_o;
  wire [20:0] pc_target_o;
  wire [21:0] table_ptr_o;
  integer err_count = 0, n_checks = 0, cyc = 0, i;
  reg [11:0] ra [0:9];
  reg [7:0] rv [0:9];

  core_sfr_bank i_core_sfr_bank (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .push_i(push_i),
    .pop_i(pop_i), .ret_addr_i(ret_addr_i), .tbl_load_i(tbl_load_i),
    .tbl_data_i(tbl_data_i), .mul_load_i(mul_load_i), .product_i(product_i),
    .pc_load_o(pc_load_o), .pc_target_o(pc_target_o), .table_ptr_o(table_ptr_o),
    .table_config_sel_o(table_config_sel_o), .table_latch_o(table_latch_o),
    .int_ctrl_main_o(int_ctrl_main_o), .irq_o(irq_o));

  // ****************************************************************
  // Clock, watchdog and closing
  // ****************************************************************
  always #10 clock_i = ~clock_i;

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clock_i)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      err_count = err_count + 1;
      close_out;
    end
  end

  task close_out;
  begin
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask

  // ****************************************************************
  // Bus tasks: one strobe cycle, then one idle cycle
  // ****************************************************************
  task wr(input [11:0] a, input [7:0] d);
  begin
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
    // Let outputs launched at this edge settle before a caller looks
    #1;
  end
  endtask

  // Data stand only in the cycle after the strobe, so sample just past that edge
  task chk(input [11:0] a, input [7:0] e);
    reg [7:0] v;
  begin
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
    @(posedge clock_i);
    n_checks = n_checks + 1;
    if (v !== e)
    begin
      err_count = err_count + 1;
      $display("mismatch at %0t: addr %h got %h exp %h", $time, a, v, e);
    end
  end
  endtask

  task cmp(input [31:0] g, input [31:0] e);
  begin
    n_checks = n_checks + 1;
    if (g !== e)
    begin
      err_count = err_count + 1;
      $display("mismatch at %0t: port got %h exp %h", $time, g, e);
    end
  end
  endtask

  // Side pulses are one cycle; 0 push, 1 pop, 2 table load, 3 product load
  task pulse(input integer k);
  begin
    push_i <= (k == 0);
    pop_i <= (k == 1);
    tbl_load_i <= (k == 2);
    mul_load_i <= (k == 3);
    @(posedge clock_i);
    {push_i, pop_i, tbl_load_i, mul_load_i} <= 4'h0;
    @(posedge clock_i);
  end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    ra[0] = `A_TBL_PTR_HIGH; rv[0] = 8'h00; ra[1] = `A_TBL_PTR_LOW; rv[1] = 8'h00;
    ra[2] = `A_TBL_LATCH; rv[2] = 8'h00; ra[3] = `A_INT_CTRL_MAIN; rv[3] = 8'h00;
    ra[4] = `A_INT_CTRL_EDGES; rv[4] = 8'hff; ra[5] = `A_INT_CTRL_EXT; rv[5] = 8'hc0;
    ra[6] = `A_STACK_POINTER; rv[6] = 8'h00; ra[7] = `A_PC_HIGH_LATCH; rv[7] = 8'h00;
    ra[8] = `A_IND0_PTR_HIGH; rv[8] = 8'h00; ra[9] = 12'hf70; rv[9] = 8'h00;
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    // Reset values, plus one unmapped place that reads zero
    for (i = 0; i < 10; i = i + 1)
      chk(ra[i], rv[i]);
    wr(12'hf70, 8'h5a);
    chk(12'hf70, 8'h00);
    // Interrupt control main word mirrored on its port
    wr(`A_INT_CTRL_MAIN, 8'ha5);
    cmp(int_ctrl_main_o, 8'ha5);
    chk(`A_INT_CTRL_MAIN, 8'ha5);
    // Table pointer with the configuration space bit set, then cleared
    wr(`A_TBL_PTR_UPPER, 8'h25);
    wr(`A_TBL_PTR_HIGH, 8'h34);
    wr(`A_TBL_PTR_LOW, 8'h56);
    @(posedge clock_i);
    cmp(table_ptr_o, {6'h25, 8'h34, 8'h56});
    cmp(table_config_sel_o, 1'b1);
    chk(`A_TBL_PTR_LOW, 8'h56);
    wr(`A_TBL_PTR_UPPER, 8'h05);
    @(posedge clock_i);
    cmp(table_config_sel_o, 1'b0);
    // Table latch from program memory, then from software
    tbl_data_i <= 8'h5a;
    pulse(2);
    chk(`A_TBL_LATCH, 8'h5a);
    cmp(table_latch_o, 8'h5a);
    wr(`A_TBL_LATCH, 8'hc3);
    chk(`A_TBL_LATCH, 8'hc3);
    // Product bytes split high and low
    product_i <= 16'habcd;
    pulse(3);
    chk(`A_PROD_HIGH, 8'hab);
    chk(`A_PROD_LOW, 8'hcd);
    // Program counter latch: bit 21 spot plus bits 20..16
    wr(`A_PC_UPPER_LATCH, 8'h3f);
    wr(`A_PC_HIGH_LATCH, 8'h12);
    wr(`A_PC_LOW_BYTE, 8'h34);
    cmp(pc_target_o, {5'h1f, 8'h12, 8'h34});
    chk(`A_PC_UPPER_LATCH, 8'h3f);
    // Pointer zero: upper nibble dropped, then the auto-modifying places
    wr(`A_IND0_PTR_HIGH, 8'hf0);
    chk(`A_IND0_PTR_HIGH, 8'h00);
    wr(`A_IND0_PTR_LOW, 8'h10);
    wr(12'h010, 8'h11);
    wr(12'h011, 8'h22);
    wr(12'h012, 8'h33);
    chk(`A_IND0_POST_INC, 8'h11);
    chk(`A_IND0_PTR_LOW, 8'h11);
    chk(`A_IND0_POST_DEC, 8'h22);
    chk(`A_IND0_PTR_LOW, 8'h10);
    chk(`A_IND0_PRE_INC, 8'h22);
    chk(`A_IND0_PTR_LOW, 8'h11);
    wr(`A_WORKING, 8'hff);
    chk(`A_IND0_PLUS_W, 8'h11);
    wr(`A_WORKING, 8'h01);
    chk(`A_IND0_PLUS_W, 8'h33);
    chk(`A_IND0_PTR_LOW, 8'h11);
    chk(`A_IND0_PLAIN, 8'h22);
    wr(`A_IND0_POST_INC, 8'ha1);
    wr(`A_IND0_POST_INC, 8'ha2);
    chk(12'h011, 8'ha1);
    chk(12'h012, 8'ha2);
    // Twelve-bit wrap from the top of the map back to zero
    wr(`A_IND0_PTR_HIGH, 8'h0f);
    wr(`A_IND0_PTR_LOW, 8'hff);
    chk(`A_IND0_POST_INC, 8'h00);
    chk(`A_IND0_PTR_HIGH, 8'h00);
    chk(`A_IND0_PTR_LOW, 8'h00);
    // Underflow event: masked first, then raised, then cleared
    pulse(1);
    chk(`A_STACK_POINTER, 8'h40);
    chk(`A_EVENT_STATUS, 8'h02);
    cmp(irq_o, 1'b0);
    wr(`A_EVENT_MASK, 8'h02);
    cmp(irq_o, 1'b1);
    wr(`A_EVENT_STATUS, 8'h02);
    cmp(irq_o, 1'b0);
    wr(`A_STACK_POINTER, 8'h00);
    // Fill the return stack; full event stays masked until enabled
    ret_addr_i <= 21'h1a_bcde;
    for (i = 0; i < 31; i = i + 1)
      pulse(0);
    chk(`A_STACK_POINTER, 8'h9f);
    chk(`A_STACK_TOP_UPPER, 8'h1a);
    chk(`A_STACK_TOP_HIGH, 8'hbc);
    chk(`A_STACK_TOP_LOW, 8'hde);
    chk(`A_EVENT_STATUS, 8'h01);
    cmp(irq_o, 1'b0);
    wr(`A_EVENT_MASK, 8'h03);
    cmp(irq_o, 1'b1);
    wr(`A_EVENT_STATUS, 8'h01);
    cmp(irq_o, 1'b0);
    close_out;
  end
endmodule // testbench
